// ===== lpddr2_write_bst_precharge.sv
// Command and write-data path of a DDR mobile memory: write, terminate, precharge.
// Assumes CK, CA, DQS, DQ and DM come from a controller; config is held steady while idle.
`timescale 1ns/100ps
`default_nettype none

module lpddr2_write_bst_precharge
  import lpddr2_wr_pkg::*;
(
  // System clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  // Link command bus
  input  wire logic               i_ck,
  input  wire logic               i_cs_n,
  input  wire logic [CA_W-1:0]    i_ca,
  // Link data lanes
  input  wire logic               i_dqs,
  output logic                    o_dqs,
  output logic                    o_dqs_oe,
  input  wire logic [DQ_W-1:0]    i_dq,
  output logic      [DQ_W-1:0]    o_dq,
  output logic                    o_dq_oe,
  input  wire logic [LANES-1:0]   i_dm,
  // Configuration, system domain
  input  wire logic [2:0]         i_burst_len,
  input  wire logic [2:0]         i_write_latency,
  input  wire logic               i_eight_bank,
  // Array observation
  input  wire logic [MEM_AW-1:0]  i_peek_addr,
  output logic      [BEAT2_W-1:0] o_peek_data,
  // Status, system domain
  output logic                    o_pre_event,
  output logic      [BANKS-1:0]   o_pre_banks,
  output logic                    o_write_active
);

  typedef struct packed {
    logic              wr;
    logic              bst;
    logic [BANK_W-1:0] bank;
    logic [PAIR_W-1:0] pair;
  } slot_t;

  lpddr2_mem_if mem_bus ();

  lpddr2_wr_array u_array (
    .i_clk_wr (i_ck),
    .i_clk_rd (i_clk_sys),
    .mem      (mem_bus.array)
  );

  // ---------------- Link clock domain ----------------

  logic                rst_meta_ck;
  logic                ck_rst_n;
  logic [6:0]          cfg_meta;
  logic [6:0]          cfg_ck;
  logic                cmd_sel;
  logic [CA_W-1:0]     ca_rise;
  logic [CA_W-1:0]     ca_fall;
  logic [DQ_W-1:0]     dq_rise;
  logic [DQ_W-1:0]     dq_fall;
  logic [LANES-1:0]    dm_rise;
  logic [LANES-1:0]    dm_fall;
  logic                last_is_write;
  slot_t               slots [0:WL_MAX-1];
  slot_t               next_slot;
  slot_t               tap;
  logic [3:0]          pairs_left;
  logic [PAIR_W-1:0]   cur_pair;
  logic [BANK_W-1:0]   cur_bank;
  logic [BANKS-1:0]    pre_banks_ck;
  logic                pre_toggle_ck;
  logic                wr_busy_ck;

  logic                is_wr;
  logic                is_rd;
  logic                is_bst;
  logic                is_pre;
  logic [3:0]          bl_pairs;
  logic [2:0]          wl_eff;
  logic                eight_ck;
  logic [PAIR_W-1:0]   wrap_mask;
  logic [PAIR_W-1:0]   pair_now;
  logic [PAIR_W-1:0]   pair_step;
  logic [BANK_W-1:0]   bank_now;
  logic                beat_write;
  logic [BANK_W-1:0]   pre_ba;
  logic [BANKS-1:0]    next_pre_banks;

  // Release of reset follows the link clock; assertion stays immediate
  always_ff @(posedge i_ck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ck <= 1'b0;
      ck_rst_n    <= 1'b0;
    end else begin
      rst_meta_ck <= 1'b1;
      ck_rst_n    <= rst_meta_ck;
    end
  end

  // Quasi-static settings from the system side, two stages
  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      cfg_meta <= 7'h00;
      cfg_ck   <= 7'h00;
    end else begin
      cfg_meta <= {i_eight_bank, i_write_latency, i_burst_len};
      cfg_ck   <= cfg_meta;
    end
  end

  always_comb begin
    eight_ck = cfg_ck[6];
    wl_eff   = (cfg_ck[5:3] < WL_MIN) ? WL_MIN : cfg_ck[5:3];
    if (cfg_ck[2:0] == BL16_CODE) begin
      bl_pairs = PAIRS_BL16;
    end else if (cfg_ck[2:0] == BL8_CODE) begin
      bl_pairs = PAIRS_BL8;
    end else begin
      bl_pairs = PAIRS_BL4;
    end
  end

  // Command half captured on the rising edge
  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      cmd_sel <= 1'b0;
      ca_rise <= 10'h000;
    end else begin
      cmd_sel <= !i_cs_n;
      ca_rise <= i_ca;
    end
  end

  // Address half captured on the falling edge
  always_ff @(negedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      ca_fall <= 10'h000;
    end else begin
      ca_fall <= i_ca;
    end
  end

  // Data and masks share one strobe capture path
  always_ff @(posedge i_dqs) begin
    dq_rise <= i_dq;
    dm_rise <= i_dm;
  end

  always_ff @(negedge i_dqs) begin
    dq_fall <= i_dq;
    dm_fall <= i_dm;
  end

  // Decode one link clock after the command, once both halves are held
  always_comb begin
    is_wr  = cmd_sel && (ca_rise[2:0] == CMD_WR_CODE);
    is_rd  = cmd_sel && (ca_rise[2:0] == CMD_RD_CODE);
    is_bst = cmd_sel && (ca_rise[3:0] == CMD_BST_CODE);
    is_pre = cmd_sel && (ca_rise[3:0] == CMD_PRE_CODE);
    next_slot.wr   = is_wr;
    next_slot.bst  = is_bst && last_is_write;
    next_slot.bank = ca_rise[CA_BA_HI:CA_BA_LO];
    next_slot.pair = {ca_fall[CA_COL_HI:CA_COL_LO], ca_rise[CA_COL2_R], ca_rise[CA_COL1_R]};
  end

  // A terminate after a read belongs to the read and leaves writes alone
  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      last_is_write <= 1'b0;
    end else if (is_wr) begin
      last_is_write <= 1'b1;
    end else if (is_rd || is_bst) begin
      last_is_write <= 1'b0;
    end
  end

  // Latency line: commands reach the data engine WL clocks later
  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      for (int i = 0; i < WL_MAX; i++) begin
        slots[i] <= '0;
      end
    end else begin
      slots[0] <= next_slot;
      for (int i = 1; i < WL_MAX; i++) begin
        slots[i] <= slots[i-1];
      end
    end
  end

  assign tap = slots[wl_eff - WL_MIN];

  // Pair k of a burst lands just before edge decode+WL+k
  always_comb begin
    wrap_mask  = {{(PAIR_W-4){1'b0}}, bl_pairs - 4'h1};
    pair_now   = tap.wr ? tap.pair : cur_pair;
    bank_now   = tap.wr ? tap.bank : cur_bank;
    beat_write = tap.wr || (!tap.bst && (pairs_left != 4'h0));
    pair_step  = (pair_now & ~wrap_mask) | ((pair_now + 11'h001) & wrap_mask);
  end

  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      pairs_left <= 4'h0;
      cur_pair   <= 11'h000;
      cur_bank   <= 3'h0;
    end else if (tap.wr) begin
      pairs_left <= bl_pairs - 4'h1;
      cur_pair   <= pair_step;
      cur_bank   <= tap.bank;
    end else if (tap.bst) begin
      pairs_left <= 4'h0;
    end else if (pairs_left != 4'h0) begin
      pairs_left <= pairs_left - 4'h1;
      cur_pair   <= pair_step;
    end
  end

  assign mem_bus.wr_en   = beat_write;
  assign mem_bus.wr_addr = {bank_now, pair_now};
  assign mem_bus.wr_data = {dq_fall, dq_rise};
  assign mem_bus.wr_be   = ~{dm_fall, dm_rise};
  assign mem_bus.rd_addr = i_peek_addr;

  // Precharge: all-bank flag or one bank; a 4-bank part drops the top bit
  always_comb begin
    pre_ba = eight_ck ? ca_rise[CA_BA_HI:CA_BA_LO] : {1'b0, ca_rise[CA_BA_LO+1:CA_BA_LO]};
    if (ca_rise[CA_AB_R]) begin
      next_pre_banks = eight_ck ? ALL_BANKS_8 : ALL_BANKS_4;
    end else begin
      next_pre_banks = 8'h01 << pre_ba;
    end
  end

  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      pre_banks_ck  <= PRE_BANKS_RST;
      pre_toggle_ck <= 1'b0;
    end else if (is_pre) begin
      pre_banks_ck  <= next_pre_banks;
      pre_toggle_ck <= !pre_toggle_ck;
    end
  end

  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      wr_busy_ck <= 1'b0;
    end else begin
      wr_busy_ck <= beat_write || next_slot.wr;
    end
  end

  // ---------------- System clock domain ----------------

  logic [2:0] pre_tog_sync;
  logic [1:0] busy_sync;

  // Bank set is held steady from its toggle until well after the third stage
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_tog_sync <= 3'h0;
      busy_sync    <= 2'h0;
    end else begin
      pre_tog_sync <= {pre_tog_sync[1:0], pre_toggle_ck};
      busy_sync    <= {busy_sync[0], wr_busy_ck};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pre_event <= 1'b0;
      o_pre_banks <= PRE_BANKS_RST;
    end else begin
      o_pre_event <= pre_tog_sync[2] ^ pre_tog_sync[1];
      if (pre_tog_sync[2] ^ pre_tog_sync[1]) begin
        o_pre_banks <= pre_banks_ck;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_write_active <= 1'b0;
    end else begin
      o_write_active <= busy_sync[1];
    end
  end

  // Reads are outside this block, so the data lanes stay released
  always_ff @(posedge i_ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
      o_dq     <= 32'h0000_0000;
      o_dq_oe  <= 1'b0;
    end else begin
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
      o_dq     <= 32'h0000_0000;
      o_dq_oe  <= 1'b0;
    end
  end

  assign o_peek_data = mem_bus.rd_data;

endmodule

`default_nettype wire

// ===== lpddr2_wr_pkg.sv
// Constants shared by the write/terminate/precharge path and its array.
// Assumes a 10-bit DDR command bus, 32 data bits in four byte lanes and 8 banks.
package lpddr2_wr_pkg;

  // Bus and array geometry
  localparam int CA_W    = 10;
  localparam int DQ_W    = 32;
  localparam int LANES   = 4;
  localparam int BANK_W  = 3;
  localparam int BANKS   = 8;
  localparam int PAIR_W  = 11;
  localparam int MEM_AW  = BANK_W + PAIR_W;
  localparam int BEAT2_W = 2 * DQ_W;
  localparam int BE2_W   = 2 * LANES;

  // Command codes on the rising-edge CA bits
  localparam logic [2:0] CMD_WR_CODE  = 3'h1;
  localparam logic [2:0] CMD_RD_CODE  = 3'h5;
  localparam logic [3:0] CMD_BST_CODE = 4'h3;
  localparam logic [3:0] CMD_PRE_CODE = 4'hB;

  // Field positions on the CA bus
  localparam int CA_COL1_R = 5;
  localparam int CA_COL2_R = 6;
  localparam int CA_AB_R   = 4;
  localparam int CA_BA_LO  = 7;
  localparam int CA_BA_HI  = 9;
  localparam int CA_COL_LO = 1;
  localparam int CA_COL_HI = 9;
  localparam int CA_AP_F   = 0;

  // Burst length codes and the beat pairs each one spans
  localparam logic [2:0] BL4_CODE  = 3'h2;
  localparam logic [2:0] BL8_CODE  = 3'h3;
  localparam logic [2:0] BL16_CODE = 3'h4;
  localparam logic [3:0] PAIRS_BL4  = 4'h2;
  localparam logic [3:0] PAIRS_BL8  = 4'h4;
  localparam logic [3:0] PAIRS_BL16 = 4'h8;

  // Write latency range in link clocks
  localparam int         WL_MAX = 8;
  localparam logic [2:0] WL_MIN = 3'h1;

  // Bank sets closed by an all-bank precharge
  localparam logic [7:0] ALL_BANKS_8 = 8'hFF;
  localparam logic [7:0] ALL_BANKS_4 = 8'h0F;

  // Reset values
  localparam logic [7:0] PRE_BANKS_RST = 8'h00;

endpackage

// ===== lpddr2_mem_if.sv
// Write and read ports between the link logic and the storage array.
// Write side belongs to the link clock, read side to the system clock.
`timescale 1ns/100ps
`default_nettype none

interface lpddr2_mem_if;
  import lpddr2_wr_pkg::*;

  logic                wr_en;
  logic [MEM_AW-1:0]   wr_addr;
  logic [BEAT2_W-1:0]  wr_data;
  logic [BE2_W-1:0]    wr_be;
  logic [MEM_AW-1:0]   rd_addr;
  logic [BEAT2_W-1:0]  rd_data;

  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_be,
    output rd_addr,
    input  rd_data
  );

  modport array (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  wr_be,
    input  rd_addr,
    output rd_data
  );

endinterface

`default_nettype wire

// ===== lpddr2_wr_array.sv
// Storage for one beat pair per word, written with per-byte enables.
// Writes on the link clock, registered reads on the system clock.
`timescale 1ns/100ps
`default_nettype none

module lpddr2_wr_array
  import lpddr2_wr_pkg::*;
(
  // Clocks
  input  wire logic i_clk_wr,
  input  wire logic i_clk_rd,
  // Ports
  lpddr2_mem_if.array mem
);

  genvar b;
  generate
    for (b = 0; b < BE2_W; b = b + 1) begin : g_lane
      // One narrow store per byte lane, so each store has a single writer
      logic [7:0] store [0:(1<<MEM_AW)-1];

      always_ff @(posedge i_clk_wr) begin
        if (mem.wr_en && mem.wr_be[b]) begin
          store[mem.wr_addr] <= mem.wr_data[b*8 +: 8];
        end
      end

      // Peek port is for observation only; a read racing a write may see either value
      always_ff @(posedge i_clk_rd) begin
        mem.rd_data[b*8 +: 8] <= store[mem.rd_addr];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== lpddr2_wbp_chk.sv
// Port assertions for the write, terminate and precharge block.
// Bound to the block top; link and system domains use their own clocks.
`timescale 1ns/100ps
`default_nettype none
module lpddr2_wbp_chk
  import lpddr2_wr_pkg::*;
(
  input wire logic             i_clk_sys,
  input wire logic             i_reset_n,
  input wire logic             i_ck,
  input wire logic             i_cs_n,
  input wire logic [CA_W-1:0]  i_ca,
  input wire logic             i_eight_bank,
  input wire logic             o_dqs_oe,
  input wire logic             o_dq_oe,
  input wire logic             o_pre_event,
  input wire logic [BANKS-1:0] o_pre_banks,
  input wire logic             o_write_active
);
  function automatic logic [7:0] sel(logic [9:0] ca, logic eb);
    if (ca[CA_AB_R])
      return eb ? ALL_BANKS_8 : ALL_BANKS_4;
    return 8'h01 << (eb ? ca[9:7] : {1'b0, ca[8:7]});
  endfunction
  sequence s_wr; !i_cs_n && i_ca[2:0] == CMD_WR_CODE; endsequence
  sequence s_bst; !i_cs_n && i_ca[3:0] == CMD_BST_CODE; endsequence
  sequence s_pre; !i_cs_n && i_ca[3:0] == CMD_PRE_CODE; endsequence
  // Precharges are spaced by at least 3 link clocks, so the mask is settled by then
  property p_banks;
    @(posedge i_ck) disable iff (!i_reset_n)
      s_pre |-> ##3 o_pre_banks == sel($past(i_ca, 3), $past(i_eight_bank, 3));
  endproperty
  chk_wr_active: assert property (@(posedge i_ck) disable iff (!i_reset_n) s_wr |-> ##[1:7] o_write_active)
    else $error("write command started no burst");
  chk_bst_stop: assert property (@(posedge i_ck) disable iff (!i_reset_n) s_bst |-> ##[1:7] !o_write_active)
    else $error("terminated write kept running");
  chk_bank_sel: assert property (p_banks)
    else $error("precharge closed the wrong banks");
  chk_pre_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) o_pre_event |=> !o_pre_event)
    else $error("precharge event longer than one cycle");
  chk_banks_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $changed(o_pre_banks) |-> o_pre_event)
    else $error("bank mask changed without precharge");
  chk_pre_nonzero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_pre_event |-> o_pre_banks != 8'h00)
    else $error("precharge closed no bank");
  chk_four_bank: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_pre_event && !i_eight_bank |-> o_pre_banks[7:4] == 4'h0)
    else $error("four-bank part closed an upper bank");
  chk_no_drive: assert property (@(posedge i_ck) disable iff (!i_reset_n) !o_dq_oe && !o_dqs_oe)
    else $error("device drove the data lanes");
endmodule
bind lpddr2_write_bst_precharge lpddr2_wbp_chk lpddr2_wbp_chk_i (.i_clk_sys, .i_reset_n, .i_ck, .i_cs_n, .i_ca,
  .i_eight_bank, .o_dqs_oe, .o_dq_oe, .o_pre_event, .o_pre_banks, .o_write_active);
`default_nettype wire

// ===== lpddr2_ctrl_model.sv
// Memory controller model: commands on CA, write data on DQ, DM and DQS.
// Bench pushes commands and beat pairs; CK comes from the bench and runs free.
`timescale 1ns/100ps
`default_nettype none
module lpddr2_ctrl_model
  import lpddr2_wr_pkg::*;
(
  input  wire logic         i_ck,
  output logic              o_cs_n,
  output logic [CA_W-1:0]   o_ca,
  output logic              o_dqs,
  output logic [DQ_W-1:0]   o_dq,
  output logic [LANES-1:0]  o_dm
);
  logic [31:0] cq [$];    // {pairs, latency, fall half, rise half}; pairs FF is idle
  logic [71:0] dq_q [$];  // {masks, fall word, rise word}
  logic [71:0] slot [64];
  bit          sv [64];
  logic [9:0]  fall;
  logic [31:0] c;
  logic [71:0] x;
  int          cyc = 0;
  int          k;
  initial begin
    o_cs_n = 1'b1;
    o_ca = '0;
    o_dqs = 1'b0;  // Strobe held low outside bursts covers the preamble
    o_dq = '0;
    o_dm = '0;
  end
  always @(posedge i_ck) begin
    cyc = cyc + 1;
    if (!o_cs_n) begin
      o_cs_n <= 1'b1;
      o_ca <= #40 fall;
    end else begin
      c = (cq.size() != 0) ? cq.pop_front() : '1;
      if (c[31:24] != 8'hFF) begin
        o_cs_n <= 1'b0;
        o_ca <= c[9:0];
        fall = c[19:10];
        // Later write overwrites slots: interrupt
        for (k = 0; k < int'(c[31:24]); k++) begin
          slot[(cyc + 1 + int'(c[23:20]) + k) % 64] = dq_q.pop_front();
          sv[(cyc + 1 + int'(c[23:20]) + k) % 64] = 1'b1;
        end
      end else begin
        o_ca <= ~o_ca;
      end
    end
    if (sv[cyc % 64]) begin
      sv[cyc % 64] = 1'b0;
      x = slot[cyc % 64];
      // Centre-aligned beats; lines inverted once hold has run out
      o_dq <= #10 x[31:0];
      o_dm <= #10 x[67:64];
      o_dqs <= #40 1'b1;
      o_dq <= #80 x[63:32];
      o_dm <= #80 x[71:68];
      o_dqs <= #120 1'b0;
      o_dq <= #150 ~x[63:32];
      o_dm <= #150 ~x[71:68];
    end
  end
endmodule
`default_nettype wire

// ===== tb_lpddr2_write_bst_precharge.sv
// Bench: masked bursts of every length, interrupt, terminate, all precharge codes.
// The controller model drives the link; the bench makes both clocks and the config.
`timescale 1ns/100ps
`default_nettype none
module tb_lpddr2_write_bst_precharge
  import lpddr2_wr_pkg::*;
();
  logic                i_clk_sys, i_reset_n, i_ck, i_cs_n, i_dqs, i_eight_bank;
  logic                o_pre_event, o_write_active, o_dqs, o_dqs_oe, o_dq_oe;
  logic [CA_W-1:0]     i_ca;
  logic [DQ_W-1:0]     i_dq, o_dq;
  logic [LANES-1:0]    i_dm;
  logic [2:0]          i_burst_len, i_write_latency, b;
  logic [MEM_AW-1:0]   i_peek_addr;
  logic [BEAT2_W-1:0]  o_peek_data;
  logic [BANKS-1:0]    o_pre_banks;
  logic [10:0]         p, q;
  logic [63:0]         exp_m [logic [13:0]];
  int                  n_mismatch = 0, comparisons = 0, bp = 2, g;
  lpddr2_write_bst_precharge lpddr2_write_bst_precharge_i (.i_clk_sys, .i_reset_n, .i_ck, .i_cs_n, .i_ca,
    .i_dqs, .o_dqs, .o_dqs_oe, .i_dq, .o_dq, .o_dq_oe, .i_dm, .i_burst_len, .i_write_latency,
    .i_eight_bank, .i_peek_addr, .o_peek_data, .o_pre_event, .o_pre_banks, .o_write_active);
  lpddr2_ctrl_model lpddr2_ctrl_model_i (.i_ck, .o_cs_n(i_cs_n), .o_ca(i_ca), .o_dqs(i_dqs), .o_dq(i_dq),
    .o_dm(i_dm));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_ck = 1'b0;
    #37;
    forever #80 i_ck = ~i_ck;
  end
  function automatic logic [63:0] mrg(logic [63:0] o, logic [71:0] x);
    logic [63:0] r;
    for (int j = 0; j < 8; j++)
      r[8*j+:8] = x[64+j] ? o[8*j+:8] : x[8*j+:8];
    return r;
  endfunction
  function automatic logic [7:0] ebank(logic ab, logic eb, logic [2:0] n);
    if (ab)
      return eb ? 8'hFF : 8'h0F;
    return 8'h01 << (eb ? n : {1'b0, n[1:0]});
  endfunction
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Lets queued traffic drain; also keeps config steady 9 link clocks ahead
  task automatic settle();
    for (int i = 0; i < 400 && (i < 30 || lpddr2_ctrl_model_i.cq.size() != 0 || o_write_active !== 1'b0); i++)
      @(posedge i_clk_sys);
    chk("idle", 64'(o_write_active), 64'h0);
    chk("lanes", 64'({o_dqs, o_dqs_oe, o_dq_oe, o_dq}), 64'h0);
  endtask
  task automatic cfg(logic [2:0] c);
    i_burst_len <= c;
    i_write_latency <= 3'(1 + $urandom % 4);
    bp = 1 << (c - 1);
    settle();
  endtask
  task automatic cmd(logic [9:0] r);
    lpddr2_ctrl_model_i.cq.push_back({12'h000, 10'($urandom), r});
  endtask
  task automatic nop(int n);
    repeat (n) lpddr2_ctrl_model_i.cq.push_back('1);
  endtask
  // Model always sends the whole burst; only the first ne pairs may land
  task automatic wr(logic [2:0] bk, logic [10:0] pa, int ne, bit m);
    logic [71:0] x;
    logic [13:0] a;
    lpddr2_ctrl_model_i.cq.push_back({8'(bp), 1'b0, i_write_latency, pa[10:2], 1'b0, bk, pa[1:0], 2'($urandom),
      CMD_WR_CODE});
    for (int k = 0; k < bp; k++) begin
      x = {m ? 8'($urandom) : 8'h00, $urandom, $urandom};
      a = {bk, (pa & ~11'(bp - 1)) | ((pa + 11'(k)) & 11'(bp - 1))};
      lpddr2_ctrl_model_i.dq_q.push_back(x);
      if (k < ne)
        exp_m[a] = mrg(exp_m.exists(a) ? exp_m[a] : x[63:0], x);
    end
  endtask
  task automatic vfy();
    settle();
    foreach (exp_m[a]) begin
      @(posedge i_clk_sys);
      i_peek_addr <= a;
      @(posedge i_clk_sys);
      @(posedge i_clk_sys);
      chk("array", o_peek_data, exp_m[a]);
    end
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(59));
    i_reset_n = 1'b1;
    i_burst_len = BL4_CODE;
    i_write_latency = WL_MIN;
    i_eight_bank = 1'b1;
    i_peek_addr = '0;
    // A real falling edge, so the link-side flops reset without a link clock edge
    #1;
    i_reset_n = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int n = 2; n < 5; n++) begin
      cfg(3'(n));
      b = 3'($urandom);
      p = 11'($urandom);
      wr(b, p, bp, 0);
      settle();
      wr(b, p, bp, 1);
      settle();
    end
    vfy();
    cfg(BL16_CODE);
    b = 3'($urandom);
    p = 11'($urandom);
    q = 11'($urandom);
    wr(b, p, 8, 0);
    settle();
    wr(b + 3'h1, q, 8, 0);
    settle();
    g = 2 * (1 + $urandom % 3);
    wr(b, p, g, 1);
    nop(g - 2);
    wr(b + 3'h1, q, 8, 1);
    settle();
    g = 2 * (1 + $urandom % 3);
    wr(b + 3'h1, q, g, 1);
    nop(g - 2);
    cmd({6'($urandom), CMD_BST_CODE});
    vfy();
    for (int i = 0; i < 32; i++) begin
      i_eight_bank <= i[4];
      settle();
      cmd({i[2:0], 2'($urandom), i[3], CMD_PRE_CODE});
      for (int j = 0; j < 40; j++) begin
        @(posedge i_clk_sys);
        if (o_pre_event === 1'b1)
          break;
      end
      chk("precharge", 64'({o_pre_event, o_pre_banks}), 64'({1'b1, ebank(i[3], i[4], i[2:0])}));
    end
    summarize();
  end
endmodule
`default_nettype wire
